// [sac_pkg.sv]
// Package for the serial attenuator control block: widths, reset values and timing constants.
// Assumes a 40 MHz pclk domain; all link pins arrive asynchronously.
package sac_pkg;
	localparam int WORD_W = 6;
	localparam logic [5:0] WORD_RESET = 6'h3F;
	localparam int SYNC_STAGES = 3;
	localparam int PCLK_HZ = 40000000;
	localparam int PCLK_PERIOD_PS = 25000;
	localparam int LE_SPACING_NS = 630;
	localparam int LE_SPACING_CYC = (LE_SPACING_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
	localparam int HALF_DB_STEPS_W = 7;
	localparam logic [6:0] HALF_DB_ZERO = 7'h00;
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h04;
	localparam logic [5:0] ADDR_SHIFT = 6'h08;
	localparam int CTRL_FREEZE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
endpackage

// [sac_link_if.sv]
// Interface carrying the synchronised link levels from the sampler to the core.
// Assumes both ends run on pclk.
interface sac_link_if;
	logic sclk_level;
	logic data_level;
	logic latch_level;
	modport sampler (output sclk_level, output data_level, output latch_level);
	modport core (input sclk_level, input data_level, input latch_level);
endinterface

// [sac_pin_sync.sv]
// Three-stage sampler for the three serial control pins.
// Assumes the pins are asynchronous to pclk; a level is accepted when stages two and three agree.
module sac_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic latch_enable,
	sac_link_if.sampler link
);
	import sac_pkg::*;
	logic [2:0] pins;
	logic [2:0] stage1;
	logic [2:0] stage2;
	logic [2:0] stage3;
	logic [2:0] level;
	assign pins = {latch_enable, serial_data_in, serial_clock};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 3'h0;
			stage2 <= 3'h0;
			stage3 <= 3'h0;
		end else begin
			stage1 <= pins;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Each pin keeps its last agreed level while stages two and three differ.
	genvar i;
	for (i = 0; i < 3; i++) begin : g_filt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				level[i] <= 1'b0;
			end else if (stage2[i] == stage3[i]) begin
				level[i] <= stage3[i];
			end
		end
	end

	assign link.sclk_level = level[0];
	assign link.data_level = level[1];
	assign link.latch_level = level[2];
endmodule

// [sac_top.sv]
// Serial attenuator control: shifts a 6-bit word in on the serial clock and latches it to the attenuator.
// Assumes a 40 MHz pclk, asynchronous link pins and an APB master on the register side.
// Operation
// - Six-bit word, most significant bit first.
// - Word is active low, binary weighted.
// - All 64 codes legal, weights summed.
// - Latch enable high blocks serial shifting.
// - Data sampled on serial clock rising edge.
// - Latch transparent while high unless the freeze bit is set, frozen when low.
module sac_top #(
	parameter int WORD_BITS = sac_pkg::WORD_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [5:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic latch_enable,
	output logic [5:0] step_attenuator,
	output logic [6:0] attenuation_half_db
);
	import sac_pkg::*;

	// Refuses any word width other than six while the design is elaborated.
	if (WORD_BITS != WORD_W) begin : g_bad_width
		$error("sac_top supports only a six-bit control word.");
	end

	sac_link_if link ();

	sac_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.serial_clock(serial_clock),
		.serial_data_in(serial_data_in),
		.latch_enable(latch_enable),
		.link(link)
	);

	logic sclk_prev;
	logic latch_prev;
	logic sclk_rise;
	logic latch_rise;
	logic [5:0] shift_word;
	logic [31:0] ctrl;
	logic freeze;
	logic [3:0] bit_count;
	logic spacing_violation;
	logic [15:0] spacing_count;
	logic [6:0] next_half_db;

	assign freeze = ctrl[CTRL_FREEZE_BIT];
	assign sclk_rise = link.sclk_level && !sclk_prev;
	assign latch_rise = link.latch_level && !latch_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev <= 1'b0;
			latch_prev <= 1'b0;
		end else begin
			sclk_prev <= link.sclk_level;
			latch_prev <= link.latch_level;
		end
	end

	// The shift register takes one bit per serial clock rising edge while latch enable is low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_word <= WORD_RESET;
		end else if (sclk_rise && !link.latch_level) begin
			shift_word <= {shift_word[4:0], link.data_level};
		end
	end

	// Counts bits since the last latch, saturating, for software to see.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_count <= 4'h0;
		end else if (latch_rise) begin
			bit_count <= 4'h0;
		end else if (sclk_rise && !link.latch_level && bit_count != 4'hF) begin
			bit_count <= bit_count + 4'h1;
		end
	end

	// The holding latch follows the shift register while latch enable is high and freeze is clear, and holds otherwise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_attenuator <= WORD_RESET;
		end else if (link.latch_level && !freeze) begin
			step_attenuator <= shift_word;
		end
	end

	// Attenuation in half-decibel steps is the sum of the weights of cleared bits.
	always_comb begin
		next_half_db = HALF_DB_ZERO;
		for (int b = 0; b < WORD_W; b++) begin
			if (!step_attenuator[b]) begin
				next_half_db = next_half_db + 7'(1 << b);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attenuation_half_db <= HALF_DB_ZERO;
		end else begin
			attenuation_half_db <= next_half_db;
		end
	end

	// Watches latch pulse spacing so software can see when the host broke it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spacing_count <= 16'(LE_SPACING_CYC);
		end else if (latch_rise) begin
			spacing_count <= 16'h0000;
		end else if (spacing_count != 16'(LE_SPACING_CYC)) begin
			spacing_count <= spacing_count + 16'h0001;
		end
	end

	// Sticky flag; a new violation wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spacing_violation <= 1'b0;
		end else if (latch_rise && spacing_count != 16'(LE_SPACING_CYC)) begin
			spacing_violation <= 1'b1;
		end else if (psel && penable && pwrite && paddr == ADDR_STATUS && pwdata[0]) begin
			spacing_violation <= 1'b0;
		end
	end

	// Control register with a freeze bit that holds the attenuator word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
			ctrl <= {31'h0, pwdata[CTRL_FREEZE_BIT]};
		end
	end

	// APB slave with one wait-free access phase; unmapped addresses answer with an error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
					ADDR_CTRL: prdata <= ctrl;
					ADDR_STATUS: prdata <= {16'h0, 1'b0, attenuation_half_db, 3'h0, spacing_violation, bit_count};
					ADDR_SHIFT: prdata <= {18'h0, shift_word, 2'h0, step_attenuator};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// [sac_props.sv]
// Port checker for sac_top.
// Assumes pclk is far faster than the serial clock.
module sac_props #(parameter int WORD_BITS = 6) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic latch_enable,
	input wire logic [5:0] step_attenuator,
	input wire logic [6:0] attenuation_half_db
);
	logic sclk_q;
	logic [5:0] sh;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			sh <= 6'h3F;
		end else begin
			sclk_q <= serial_clock;
			if (serial_clock && !sclk_q && !latch_enable)
				sh <= {sh[4:0], serial_data_in};
		end
	end
	ready_next_a: assert property (psel && !penable |=> pready) else $error("no ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	word_match_a:
		assert property ($changed(step_attenuator) |-> step_attenuator == sh) else $error("wrong word");
	weight_sum_a:
		assert property ($stable(step_attenuator) [*3] |-> attenuation_half_db == {1'b0, ~step_attenuator})
		else $error("wrong sum");
	code_range_a: assert property (attenuation_half_db <= 7'h3F) else $error("sum range");
	shift_ignored_a:
		assert property (latch_enable [*8] |=> $stable(step_attenuator)) else $error("moved in latch");
	hold_frozen_a:
		assert property ((!latch_enable) [*8] |=> $stable(step_attenuator)) else $error("moved when low");
endmodule
bind sac_top sac_props #(.WORD_BITS(WORD_BITS)) i_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.serial_clock, .serial_data_in, .latch_enable, .step_attenuator, .attenuation_half_db);

// [sac_host.sv]
// Behavioural serial host for the link pins.
// Assumes the bench calls send; the clock idles low between frames.
module sac_host (
	output logic serial_clock = 1'b0,
	output logic serial_data_in = 1'b1,
	output logic latch_enable = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic send(input logic [7:0] w, input int n, input logic hold);
		#7 latch_enable = hold;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in = w[i];
			#50 serial_clock = 1'b1;
			#100 serial_clock = 1'b0;
			#50;
		end
		serial_data_in = ~serial_data_in;
		#100 latch_enable = 1'b1;
		#100 latch_enable = 1'b0;
		#700;
	endtask
endmodule

// [serial_attenuator_control_tb.sv]
// Self-checking bench for sac_top.
// Assumes sac_host drives the link; the bench is APB master.
module serial_attenuator_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [5:0] w; logic [6:0] db;} sac_row_t;
	sac_row_t rows [8] = '{'{6'h3F, 7'h00}, '{6'h3E, 7'h01}, '{6'h3D, 7'h02}, '{6'h3B, 7'h04},
		'{6'h37, 7'h08}, '{6'h2F, 7'h10}, '{6'h1F, 7'h20}, '{6'h00, 7'h3F}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_clock, serial_data_in, latch_enable, er;
	logic [5:0] paddr, step_attenuator;
	logic [6:0] attenuation_half_db;
	logic [31:0] pwdata, prdata, rd;
	int n_errors, checks;
	sac_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.serial_clock, .serial_data_in, .latch_enable, .step_attenuator, .attenuation_half_db);
	sac_host i_host (.serial_clock, .serial_data_in, .latch_enable);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(step_attenuator, 6'h3F);
		chk(attenuation_half_db, 7'h00);
		apb(1'b0, 6'h00, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			i_host.send({2'b00, rows[i].w}, 6, 1'b0);
			chk(step_attenuator, rows[i].w);
			chk(attenuation_half_db, rows[i].db);
		end
		apb(1'b0, 6'h04, 32'h0);
		chk(rd, 32'h00003F00);
		apb(1'b0, 6'h08, 32'h0);
		chk(rd, 32'h00000000);
		$display("table test done");
		i_host.send(8'hD2, 8, 1'b0);
		chk(step_attenuator, 6'h12);
		i_host.send(8'h2D, 6, 1'b1);
		chk(step_attenuator, 6'h12);
		apb(1'b0, 6'h0C, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 6'h00, 32'h1);
		apb(1'b0, 6'h00, 32'h0);
		chk(rd, 32'h1);
		i_host.send(8'h21, 6, 1'b0);
		chk(step_attenuator, 6'h12);
		$display("awkward tests done");
		stop_test();
	end
endmodule
